// file: mrs_line_model.sv
`timescale 1ns/10ps
module mrs_line_model #(
  parameter BIT = 86
) (
  // Clock
  input wire       core_clk,
  // Line
  input wire       txd,
  input wire       tx_en,
  input wire [2:0] fmt,
  output reg       rxd,
  // Received reply
  output reg       got,
  output reg [8:0] got_val
);
  integer   i;
  reg       err;
  reg [7:0] v;
  function hp(input [2:0] f);
    hp = f == 3'h1 || f == 3'h2 || f == 3'h4 || f == 3'h5;
  endfunction
  function pb(input [2:0] f, input [7:0] d);
    pb = (f == 3'h2 || f == 3'h5) ? ~^d : ^d;
  endfunction
  task drv(input b);
    begin
      rxd <= b;
      repeat (BIT) @(posedge core_clk);
    end
  endtask
  task send(input [7:0] d, input [1:0] bad);
    integer j;
    begin
      @(posedge core_clk);
      drv(1'b0);
      for (j = 0; j < 8; j = j + 1)
        drv(d[j]);
      if (hp(fmt))
        drv(pb(fmt, d) ^ bad[0]);
      drv(!bad[1]);
      if (fmt >= 3'h3)
        drv(1'b1);
      // Back to idle after a broken stop bit
      rxd <= 1'b1;
    end
  endtask
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_val = 9'h000;
  end
  // Receive one reply character, flag framing or parity faults
  always begin
    @(posedge core_clk);
    got <= 1'b0;
    if (tx_en && !txd) begin
      repeat (BIT / 2) @(posedge core_clk);
      err = txd;
      for (i = 0; i < 8; i = i + 1) begin
        repeat (BIT) @(posedge core_clk);
        v[i] = txd;
      end
      if (hp(fmt)) begin
        repeat (BIT) @(posedge core_clk);
        err = err | (txd != pb(fmt, v));
      end
      repeat (BIT) @(posedge core_clk);
      err = err | !txd;
      if (fmt >= 3'h3) begin
        repeat (BIT) @(posedge core_clk);
        err = err | !txd;
      end
      got_val <= {err, v};
      got <= 1'b1;
    end
  end
endmodule

// file: mrs_props.sv
`timescale 1ns/10ps
module mrs_props (
  // Clock and reset
  input wire        core_clk,
  input wire        rst_n,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Line and drive side
  input wire        txd,
  input wire        tx_en,
  input wire        comm_fault,
  input wire        irq
);
  wire        wr = psel && penable && pwrite;
  wire        frm = wr && paddr == 12'h000 && pwdata[8];
  wire        tw = wr && paddr == 12'h008 && pwdata[9:0] <= 10'h258;
  wire        tz = tw && pwdata[9:0] == 10'h000;
  reg  [15:0] dc;
  reg  [15:0] oc;
  reg         bc;
  reg         tnz;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Cycles since frame, line hold time, last frame kind
  always @(posedge core_clk) begin
    if (!rst_n) begin
      dc  <= 16'h0000;
      oc  <= 16'h0000;
      bc  <= 1'b0;
      tnz <= 1'b0;
    end else begin
      dc <= frm ? 16'h0000 : (&dc ? dc : dc + 16'h0001);
      oc <= tx_en ? oc + 16'h0001 : 16'h0000;
      if (frm)
        bc <= pwdata[23:16] == 8'h00;
      if (tw)
        tnz <= !tz;
    end
  end
  property p_rst;
    disable iff (1'b0) !rst_n |=> txd && !tx_en && !comm_fault && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_idle; !tx_en |-> txd; endproperty
  a_idle: assert property (p_idle) else $error("line not idle");
  property p_start; $rose(tx_en) |-> !txd; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_dly; $rose(tx_en) |-> dc >= 16'h2700; endproperty
  a_dly: assert property (p_dly) else $error("reply too early");
  property p_bc; $rose(tx_en) |-> !bc; endproperty
  a_bc: assert property (p_bc) else $error("broadcast answered");
  property p_on; $fell(tx_en) |-> oc >= 16'h0350; endproperty
  a_on: assert property (p_on) else $error("char too short");
  property p_fclr; tz |-> ##2 !comm_fault; endproperty
  a_fclr: assert property (p_fclr) else $error("fault kept");
  property p_fen; $rose(comm_fault) |-> tnz; endproperty
  a_fen: assert property (p_fen) else $error("fault while off");
  property p_fhold; $fell(comm_fault) |-> $past(tz, 2); endproperty
  a_fhold: assert property (p_fhold) else $error("fault lost");
  c_tx: cover property ($rose(tx_en));
  c_frm: cover property (frm);
  c_irq: cover property ($rose(irq));
endmodule

// file: mrs_regs.vh
// Behaviour
// - Acts as Modbus RTU slave on one-master multi-drop RS-485, RTU framing only.
// - Station address accepts 1 to 247, defaults to 1.
// - Address 0 is broadcast and is accepted by every slave.
// - Baud codes 0..5 give 4800 to 115200 bps, default code 1.
// - Format codes 0..5: N/E/O with 1 stop, then N/E/O with 2 stops.
// - Format defaults to code 0: 8 data, no parity, 1 stop.
// - Parity options generate and check one even or odd parity bit.
// - Master and slaves share baud, format and protocol settings.
// - Interval between valid frames above timeout flags timeout; zero disables.
// - Timeout spans 0.0 to 60.0 s, default 0.0, also in master-slave mode.
// - Timeout raises a communication protection fault.
// - Reply waits configurable delay 1 to 20 ms, default 2 ms, never zero.
// - Delay counts from end of valid request to start of reply.
// - Memory write request adds memory operation time to the delay.
// - Frame is valid only with correct function code, length and CRC.
`ifndef MRS_REGS_VH
`define MRS_REGS_VH
`define MRS_CLK_HZ        10000000
`define MRS_BPS_0         4800
`define MRS_BPS_1         9600
`define MRS_BPS_2         19200
`define MRS_BPS_3         38400
`define MRS_BPS_4         57600
`define MRS_BPS_5         115200
`define MRS_OFS_CTRL      12'h000
`define MRS_OFS_CFG       12'h004
`define MRS_OFS_TIMING    12'h008
`define MRS_OFS_STATUS    12'h00c
`define MRS_OFS_MASK      12'h010
`define MRS_OFS_RXDATA    12'h014
`define MRS_OFS_TXDATA    12'h018
`define MRS_ADDR_DEF      8'h01
`define MRS_ADDR_MAX      8'hf7
`define MRS_ADDR_BCAST    8'h00
`define MRS_BAUD_DEF      3'h1
`define MRS_FMT_DEF       3'h0
`define MRS_TMO_DEF       10'h000
`define MRS_TMO_MAX       10'h258
`define MRS_DLY_DEF       5'h02
`define MRS_DLY_MIN       5'h01
`define MRS_DLY_MAX       5'h14
`define MRS_TICK_MS       14'h2710
`define MRS_TICK_100MS    12'h063
`define MRS_ST_RXBYTE     0
`define MRS_ST_PERR       1
`define MRS_ST_FERR       2
`define MRS_ST_TMO        3
`define MRS_ST_TXDONE     4
`endif

// file: mrs_serial_port.v
`timescale 1ns/10ps
`include "mrs_regs.vh"
module mrs_serial_port #(
  parameter NVM_MS = 10
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // RS-485 line
  input  wire        rxd,
  output reg         txd,
  output reg         tx_en,
  // Drive side
  output wire        comm_fault,
  output wire        irq
);
  localparam S_IDLE = 2'h0;
  localparam S_WAIT = 2'h1;
  localparam S_SEND = 2'h2;
  reg  [7:0]  addr_reg;
  reg  [2:0]  baud_reg;
  reg  [2:0]  fmt_reg;
  reg  [9:0]  tmo_reg;
  reg  [4:0]  dly_reg;
  reg  [4:0]  sts_reg;
  reg  [4:0]  mask_reg;
  reg  [7:0]  rxdata_reg;
  reg         fault_reg;
  reg         rx_s1_reg;
  reg         rx_s2_reg;
  reg  [15:0] rx_cnt_reg;
  reg  [3:0]  rx_bit_reg;
  reg  [8:0]  rx_sh_reg;
  reg         rx_busy_reg;
  reg  [15:0] tx_cnt_reg;
  reg  [3:0]  tx_bit_reg;
  reg  [11:0] tx_sh_reg;
  reg  [1:0]  st_reg;
  reg  [13:0] ms_cnt_reg;
  reg  [11:0] ht_cnt_reg;
  reg  [5:0]  dly_cnt_reg;
  reg  [9:0]  gap_cnt_reg;
  reg  [7:0]  tx_byte_reg;
  wire [15:0] bit_len;
  wire [3:0]  nbits;
  wire        par_on;
  wire        wr;
  wire        rd;
  wire        ms_tick;
  wire        ht_tick;
  wire        rx_done;
  wire        rx_perr;
  wire        rx_ferr;
  wire        frame_ok;
  wire        own_addr;
  wire        nvm;
  wire        tx_start;
  wire        tx_done;
  wire [4:0]  ev;

  ////////////////////////////////////////////////////////////////////////
  // Bit period in clocks for a baud code
  function [15:0] baud_div;
    input [2:0] code;
    reg   [31:0] q;
    begin
      case (code)
        3'h0:    q = `MRS_CLK_HZ / `MRS_BPS_0;
        3'h1:    q = `MRS_CLK_HZ / `MRS_BPS_1;
        3'h2:    q = `MRS_CLK_HZ / `MRS_BPS_2;
        3'h3:    q = `MRS_CLK_HZ / `MRS_BPS_3;
        3'h4:    q = `MRS_CLK_HZ / `MRS_BPS_4;
        default: q = `MRS_CLK_HZ / `MRS_BPS_5;
      endcase
      // Every divisor fits in 16 bits
      baud_div = q[15:0];
    end
  endfunction

  // Parity bit for a byte and format code
  function par_bit;
    input [7:0] d;
    input [2:0] code;
    begin
      // Even codes 1 and 4, odd codes 2 and 5
      if (code == 3'h2 || code == 3'h5) begin
        par_bit = ~(^d);
      end else begin
        par_bit = ^d;
      end
    end
  endfunction

  // Format decode
  assign par_on  = (fmt_reg != 3'h0) && (fmt_reg != 3'h3);
  assign bit_len = baud_div(baud_reg);
  // Start + 8 data + parity + stops
  assign nbits = 4'h9 + {3'h0, par_on} + ((fmt_reg > 3'h2) ? 4'h2 : 4'h1);

  ////////////////////////////////////////////////////////////////////////
  // APB decode, zero wait state
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;

  // Read mux
  always @* begin
    case (paddr)
      `MRS_OFS_CTRL:   prdata = {24'h0, addr_reg};
      `MRS_OFS_CFG:    prdata = {26'h0, fmt_reg, baud_reg};
      `MRS_OFS_TIMING: prdata = {11'h0, dly_reg, 6'h0, tmo_reg};
      `MRS_OFS_STATUS: prdata = {26'h0, fault_reg, sts_reg};
      `MRS_OFS_MASK:   prdata = {27'h0, mask_reg};
      `MRS_OFS_RXDATA: prdata = {23'h0, rx_busy_reg, rxdata_reg};
      default:         prdata = 32'h0;
    endcase
  end

  // Configuration registers, out-of-range writes ignored
  always @(posedge core_clk) begin
    if (!rst_n) begin
      addr_reg <= `MRS_ADDR_DEF;
      baud_reg <= `MRS_BAUD_DEF;
      fmt_reg  <= `MRS_FMT_DEF;
      tmo_reg  <= `MRS_TMO_DEF;
      dly_reg  <= `MRS_DLY_DEF;
      mask_reg <= 5'h0;
      tx_byte_reg <= 8'h0;
    end else if (wr) begin
      case (paddr)
        `MRS_OFS_CTRL:
          if (pwdata[7:0] != `MRS_ADDR_BCAST &&
              pwdata[7:0] <= `MRS_ADDR_MAX) begin
            addr_reg <= pwdata[7:0];
          end
        `MRS_OFS_CFG: begin
          if (pwdata[2:0] <= 3'h5) begin
            baud_reg <= pwdata[2:0];
          end
          if (pwdata[5:3] <= 3'h5) begin
            fmt_reg <= pwdata[5:3];
          end
        end
        `MRS_OFS_TIMING: begin
          if (pwdata[9:0] <= `MRS_TMO_MAX) begin
            tmo_reg <= pwdata[9:0];
          end
          if (pwdata[20:16] >= `MRS_DLY_MIN &&
              pwdata[20:16] <= `MRS_DLY_MAX) begin
            dly_reg <= pwdata[20:16];
          end
        end
        `MRS_OFS_MASK:   mask_reg <= pwdata[4:0];
        `MRS_OFS_TXDATA: tx_byte_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line synchroniser
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rxd;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // Receiver, samples mid-bit, data LSB first
  assign rx_done = rx_busy_reg && (rx_cnt_reg == 16'h0) &&
                   (rx_bit_reg == 4'h9 + {3'h0, par_on});
  assign rx_ferr = rx_done && !rx_s2_reg;
  assign rx_perr = rx_done && par_on &&
                   (rx_sh_reg[8] != par_bit(rx_sh_reg[7:0], fmt_reg));
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg  <= 16'h0;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 9'h0;
      rxdata_reg  <= 8'h0;
    end else if (!rx_busy_reg) begin
      if (!rx_s2_reg) begin
        rx_busy_reg <= 1'b1;
        rx_cnt_reg  <= {1'b0, bit_len[15:1]};
        rx_bit_reg  <= 4'h0;
      end
    end else if (rx_cnt_reg != 16'h0) begin
      rx_cnt_reg <= rx_cnt_reg - 16'h1;
    end else if (rx_done) begin
      rx_busy_reg <= 1'b0;
      rxdata_reg  <= rx_sh_reg[7:0];
    end else begin
      rx_cnt_reg <= bit_len - 16'h1;
      rx_bit_reg <= rx_bit_reg + 4'h1;
      if (rx_bit_reg == 4'h0 && rx_s2_reg) begin
        rx_busy_reg <= 1'b0; // False start
      end
      if (rx_bit_reg != 4'h0) begin
        if (par_on) begin
          rx_sh_reg <= {rx_s2_reg, rx_sh_reg[8:1]};
        end else begin
          rx_sh_reg <= {1'b0, rx_s2_reg, rx_sh_reg[7:1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame qualification from the frame parser on the core side
  // Validity means function code, length and CRC checked upstream
  assign frame_ok = wr && (paddr == `MRS_OFS_CTRL) && pwdata[8];
  assign own_addr = pwdata[23:16] == addr_reg;
  assign nvm      = pwdata[9];

  // Time bases: 1 ms and 100 ms enables
  assign ms_tick = ms_cnt_reg == `MRS_TICK_MS - 14'h1;
  assign ht_tick = ms_tick && ht_cnt_reg == `MRS_TICK_100MS;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ms_cnt_reg <= 14'h0;
      ht_cnt_reg <= 12'h0;
    end else begin
      ms_cnt_reg <= ms_tick ? 14'h0 : ms_cnt_reg + 14'h1;
      if (ms_tick) begin
        ht_cnt_reg <= (ht_cnt_reg == `MRS_TICK_100MS) ? 12'h0 :
                      ht_cnt_reg + 12'h1;
      end
    end
  end

  // Watchdog on interval between valid frames, 0.1 s units
  always @(posedge core_clk) begin
    if (!rst_n) begin
      gap_cnt_reg <= 10'h0;
      fault_reg   <= 1'b0;
    end else if (frame_ok || tmo_reg == 10'h0) begin
      gap_cnt_reg <= 10'h0;
      if (tmo_reg == 10'h0) begin
        fault_reg <= 1'b0;
      end
    end else if (ht_tick) begin
      if (gap_cnt_reg >= tmo_reg) begin
        fault_reg <= 1'b1;
      end else begin
        gap_cnt_reg <= gap_cnt_reg + 10'h1;
      end
    end
  end
  assign comm_fault = fault_reg;

  ////////////////////////////////////////////////////////////////////////
  // Reply scheduler: delay then send the staged byte
  assign tx_start = (st_reg == S_WAIT) && ms_tick && dly_cnt_reg == 6'h0;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg      <= S_IDLE;
      dly_cnt_reg <= 6'h0;
    end else begin
      case (st_reg)
        S_IDLE:
          if (frame_ok && own_addr) begin
            st_reg <= S_WAIT;
            dly_cnt_reg <= {1'b0, dly_reg} +
                           (nvm ? NVM_MS[5:0] : 6'h0);
          end
        S_WAIT:
          if (ms_tick) begin
            if (dly_cnt_reg == 6'h0) begin
              st_reg <= S_SEND;
            end else begin
              dly_cnt_reg <= dly_cnt_reg - 6'h1;
            end
          end
        S_SEND:
          if (tx_done) begin
            st_reg <= S_IDLE;
          end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // Transmitter, LSB first, optional parity, 1 or 2 stops
  assign tx_done = tx_en && tx_cnt_reg == 16'h0 && tx_bit_reg == nbits - 4'h1;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      txd        <= 1'b1;
      tx_en      <= 1'b0;
      tx_cnt_reg <= 16'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg  <= 12'hfff;
    end else if (tx_start) begin
      tx_en      <= 1'b1;
      txd        <= 1'b0;
      tx_cnt_reg <= bit_len - 16'h1;
      tx_bit_reg <= 4'h0;
      if (par_on) begin
        tx_sh_reg <= {3'h7, par_bit(tx_byte_reg, fmt_reg),
                      tx_byte_reg};
      end else begin
        tx_sh_reg <= {4'hf, tx_byte_reg};
      end
    end else if (tx_en) begin
      if (tx_done) begin
        tx_en <= 1'b0;
        txd   <= 1'b1;
      end else if (tx_cnt_reg == 16'h0) begin
        tx_cnt_reg <= bit_len - 16'h1;
        tx_bit_reg <= tx_bit_reg + 4'h1;
        txd        <= tx_sh_reg[0];
        tx_sh_reg  <= {1'b1, tx_sh_reg[11:1]};
      end else begin
        tx_cnt_reg <= tx_cnt_reg - 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared by read, set wins
  assign ev = {tx_done, ht_tick && tmo_reg != 10'h0 && !fault_reg &&
               gap_cnt_reg >= tmo_reg, rx_ferr, rx_perr, rx_done};
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sts_reg <= 5'h0;
    end else if (rd && paddr == `MRS_OFS_STATUS) begin
      sts_reg <= ev;
    end else begin
      sts_reg <= sts_reg | ev;
    end
  end
  assign irq = |(sts_reg & mask_reg);
endmodule

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  reg         core_clk, rst_n, psel, penable, pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, e;
  wire [31:0] prdata;
  wire        pready, pslverr, rxd, txd, tx_en, comm_fault, irq, got;
  wire [8:0]  got_val;
  reg  [2:0]  fmt;
  reg  [7:0]  sa, b;
  integer     seed, n_mismatch, samples_checked, k, n;
  reg  [31:0] qe[$], qm[$];
  reg  [8:0]  qt[$];
  // Clock
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  mrs_serial_port #(.NVM_MS(1)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .tx_en(tx_en), .comm_fault(comm_fault), .irq(irq));
  mrs_line_model M (.core_clk(core_clk), .txd(txd), .tx_en(tx_en),
    .fmt(fmt), .rxd(rxd), .got(got), .got_val(got_val));
  task cmp(input [31:0] x, input [31:0] a);
    begin
      samples_checked = samples_checked + 1;
      if (a !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t exp=%h got=%h", $time, x, a);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task fail;
    begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      t = 0;
      @(posedge core_clk);
      while (!pready) begin
        t = t + 1;
        if (t > 50) fail;
        @(posedge core_clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] x, input [31:0] m);
    begin
      qe.push_back(x);
      qm.push_back(m);
      apb(1'b0, a, 32'h0);
    end
  endtask
  // Compare read data and reply characters against notes
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite) begin
      e = qe.pop_front();
      cmp(e, prdata & qm.pop_front());
    end
    if (psel && penable && pready)
      cmp(32'h0, {31'h0, pslverr});
    if (got)
      cmp({23'h0, qt.pop_front()}, {23'h0, got_val});
  end
  // Main sequence
  initial begin
    seed = 23525;
    n_mismatch = 0;
    samples_checked = 0;
    {rst_n, psel, penable, pwrite, paddr, pwdata, fmt} = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(12'h000, 32'h1, ~32'h0);
    rd(12'h004, 32'h1, ~32'h0);
    rd(12'h008, 32'h20000, ~32'h0);
    rd(12'h01c, 32'h0, ~32'h0);
    apb(1'b1, 12'h000, 32'h0);
    rd(12'h000, 32'h1, ~32'h0);
    apb(1'b1, 12'h000, 32'hf8);
    rd(12'h000, 32'h1, ~32'h0);
    apb(1'b1, 12'h000, 32'hf7);
    rd(12'h000, 32'hf7, ~32'h0);
    apb(1'b1, 12'h008, 32'h150259);
    rd(12'h008, 32'h20000, ~32'h0);
    apb(1'b1, 12'h008, 32'h10000);
    cmp(32'h0, {31'h0, comm_fault});
    sa = $unsigned($random(seed)) % 247 + 1;
    apb(1'b1, 12'h000, {24'h0, sa});
    apb(1'b1, 12'h010, 32'h1);
    $display("test settings done");
    for (k = 0; k < 6; k = k + 1) begin
      fmt <= k;
      apb(1'b1, 12'h004, {26'h0, k[2:0], 3'h5});
      rd(12'h004, {26'h0, k[2:0], 3'h5}, ~32'h0);
      b = $random(seed);
      M.send(b, 2'b00);
      repeat (4) @(posedge core_clk);
      cmp(32'h1, {31'h0, irq});
      rd(12'h014, {24'h0, b}, 32'hff);
      rd(12'h00c, 32'h1, 32'h3);
      @(posedge core_clk);
      cmp(32'h0, {31'h0, irq});
      // Parity formats get a bad parity bit, the others a low stop bit
      M.send(b, (k % 3 != 0) ? 2'b01 : 2'b10);
      repeat (4) @(posedge core_clk);
      rd(12'h00c, (k % 3 != 0) ? 32'h2 : 32'h4, 32'h6);
    end
    $display("test receive done");
    fmt <= $unsigned($random(seed)) % 6;
    @(posedge core_clk);
    apb(1'b1, 12'h004, {26'h0, fmt, 3'h5});
    b = $random(seed);
    apb(1'b1, 12'h018, {24'h0, b});
    qt.push_back({1'b0, b});
    apb(1'b1, 12'h000, {8'h0, sa, 8'h01, sa});
    n = 0;
    while (!got) begin
      n = n + 1;
      if (n > 40000) fail;
      @(posedge core_clk);
    end
    // Stop bits still on the line, wait for the end of the character
    n = 0;
    while (tx_en) begin
      n = n + 1;
      if (n > 2000) fail;
      @(posedge core_clk);
    end
    rd(12'h00c, 32'h10, 32'h10);
    $display("test reply done");
    // Broadcast and foreign-address frames must get no reply, here supervision is off
    apb(1'b1, 12'h000, {16'h0001, sa});
    apb(1'b1, 12'h000, {8'h0, sa ^ 8'h02, 8'h01, sa});
    n = 0;
    repeat (32000) begin
      @(posedge core_clk);
      if (tx_en) n = n + 1;
    end
    cmp(32'h0, n);
    $display("test broadcast done");
    test_done;
  end
endmodule
bind mrs_serial_port mrs_props P (.core_clk(core_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .txd(txd), .tx_en(tx_en), .comm_fault(comm_fault),
  .irq(irq));
